/* File: logic/adc_antenna_ctrl.sv */
// Antenna driver control: APB registers, driver gating and inversion, automatic switch on and off
module adc_antenna_ctrl #(
  parameter int ACTIVE_DELAY  = adc_pkg::ACTIVE_DELAY_CYCLES,
  parameter int INITIAL_DELAY = adc_pkg::INITIAL_DELAY_CYCLES,
  parameter int SLOT_N        = adc_pkg::COLL_SLOT_N
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Transmit side
  input  wire logic               carrier,
  input  wire logic               tx_envelope,
  input  wire logic               tx_last_bit_done,
  input  wire logic [1:0]         driver_source_select,
  // Field detector and power
  input  wire logic               ext_field,
  input  wire logic               soft_power_down,
  // Analog drive
  output adc_pkg::adc_drive_s     antenna_drive,
  output logic                    full_ask_force,
  output logic                    collision_avoid_on,
  output logic [3:0]              collision_slot_n,
  output logic                    wake_request
);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0]         drv_ctrl;
  logic [7:0]         auto_ctrl;
  adc_pkg::adc_auto_e state;
  adc_pkg::adc_auto_e next_state;
  logic               own_field_on;

  wire access   = psel && penable;
  wire wr_fire  = access && pwrite && pready && pstrb[0];
  wire sel_drv  = (paddr == adc_pkg::ADDR_DRV_CTRL);
  wire sel_auto = (paddr == adc_pkg::ADDR_AUTO_CTRL);
  wire sel_stat = (paddr == adc_pkg::ADDR_STATUS);
  wire mapped   = sel_drv || sel_auto || sel_stat;
  wire wr_drv   = wr_fire && sel_drv;
  wire wr_auto  = wr_fire && sel_auto;

  // A register write may only raise enable bits when the field check allows it; the automatic sequencer raises them regardless
  wire       check_block = pwdata[adc_pkg::DC_FIELD_CHECK] && ext_field;
  wire [1:0] wr_en_bits  = check_block ? (pwdata[1:0] & drv_ctrl[1:0]) : pwdata[1:0];

  // ----------------------------------------------------------------
  // Automatic sequencer
  // ----------------------------------------------------------------
  wire        auto_any   = auto_ctrl[adc_pkg::AC_DRV2_AUTO] || auto_ctrl[adc_pkg::AC_DRV1_AUTO];
  wire        init_mode  = auto_ctrl[adc_pkg::AC_INIT_AVOID];
  wire        timer_run  = (state == adc_pkg::ADC_DELAY) && !ext_field;
  wire [15:0] delay_lim  = init_mode ? 16'(INITIAL_DELAY) : 16'(ACTIVE_DELAY);
  wire        delay_done;
  wire        auto_on    = (state == adc_pkg::ADC_DELAY) && delay_done;
  wire        auto_off   = auto_ctrl[adc_pkg::AC_AUTO_OFF] && tx_last_bit_done;

  adc_delay_timer #(
    .CNT_W (16)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (timer_run),
    .limit   (delay_lim),
    .expired (delay_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      adc_pkg::ADC_IDLE: begin
        if (auto_any && !own_field_on) begin
          next_state = init_mode ? adc_pkg::ADC_DELAY : adc_pkg::ADC_WAIT_FIELD_OFF;
        end
      end
      adc_pkg::ADC_WAIT_FIELD_OFF: begin
        if (!ext_field) begin
          next_state = adc_pkg::ADC_DELAY;
        end
      end
      adc_pkg::ADC_DELAY: begin
        if (!auto_any) begin
          next_state = adc_pkg::ADC_IDLE;
        end else if (ext_field) begin
          next_state = adc_pkg::ADC_WAIT_FIELD_OFF;
        end else if (delay_done) begin
          next_state = adc_pkg::ADC_DONE;
        end
      end
      adc_pkg::ADC_DONE: begin
        if (!own_field_on) begin
          next_state = adc_pkg::ADC_IDLE;
        end
      end
      default: next_state = adc_pkg::ADC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adc_pkg::ADC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Register writes and hardware updates
  // ----------------------------------------------------------------
  wire [1:0] auto_en_set = {auto_on && auto_ctrl[adc_pkg::AC_DRV2_AUTO],
                            auto_on && auto_ctrl[adc_pkg::AC_DRV1_AUTO]};
  wire [7:0] drv_wdata   = {pwdata[7:3], 1'b0, wr_en_bits};
  wire [7:0] drv_base    = wr_drv ? drv_wdata : drv_ctrl;
  wire [1:0] en_after    = auto_off ? 2'b00 : drv_base[1:0];
  wire [7:0] next_drv    = {drv_base[7:2], en_after | auto_en_set};

  // Self clear of initial avoidance wins over a write in the same cycle, once own field is up
  wire [7:0] auto_base   = wr_auto ? (pwdata[7:0] & adc_pkg::AUTO_CTRL_WMASK) : auto_ctrl;
  wire       init_clear  = |next_drv[1:0];
  wire [7:0] next_auto   = init_clear ? (auto_base & ~(8'h01 << adc_pkg::AC_INIT_AVOID)) : auto_base;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_ctrl     <= adc_pkg::DRV_CTRL_RESET;
      auto_ctrl    <= adc_pkg::AUTO_CTRL_RESET;
      own_field_on <= 1'b0;
    end else begin
      drv_ctrl     <= next_drv;
      auto_ctrl    <= next_auto;
      own_field_on <= |next_drv[1:0];
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait-free access phase
  // ----------------------------------------------------------------
  wire [7:0]  status_byte = {4'h0, ext_field, own_field_on, state == adc_pkg::ADC_DONE,
                             state == adc_pkg::ADC_DELAY};
  wire [7:0]  rd_byte     = sel_drv  ? (drv_ctrl & adc_pkg::DRV_CTRL_RMASK) :
                            sel_auto ? auto_ctrl :
                            sel_stat ? status_byte : 8'h00;
  wire        setup       = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite) ? {24'h0, rd_byte} : 32'h0;
      pslverr <= setup && !mapped;
    end
  end

  // ----------------------------------------------------------------
  // Driver output shaping
  // ----------------------------------------------------------------
  function automatic logic drive_level(input logic en, input logic inv_on, input logic inv_off,
                                       input logic src);
    logic raw;
    raw = en ? src : 1'b0;
    drive_level = raw ^ (en ? inv_on : inv_off);
  endfunction

  wire src_coder = carrier && !tx_envelope;
  wire src_high  = (driver_source_select == 2'(adc_pkg::ADC_SRC_HIGH));
  wire src1      = src_high ? 1'b1 : src_coder;
  wire src2      = src_high ? 1'b1 : (drv_ctrl[adc_pkg::DC_DRV2_CW] ? carrier : src_coder);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      antenna_drive      <= '0;
      full_ask_force     <= 1'b0;
      collision_avoid_on <= 1'b0;
      collision_slot_n   <= 4'h0;
      wake_request       <= 1'b0;
    end else begin
      antenna_drive.drv1    <= drive_level(drv_ctrl[adc_pkg::DC_DRV1_EN], drv_ctrl[adc_pkg::DC_DRV1_INV_ON],
                                           drv_ctrl[adc_pkg::DC_DRV1_INV_OFF], src1);
      antenna_drive.drv2    <= drive_level(drv_ctrl[adc_pkg::DC_DRV2_EN], drv_ctrl[adc_pkg::DC_DRV2_INV_ON],
                                           drv_ctrl[adc_pkg::DC_DRV2_INV_OFF], src2);
      antenna_drive.drv1_on <= drv_ctrl[adc_pkg::DC_DRV1_EN];
      antenna_drive.drv2_on <= drv_ctrl[adc_pkg::DC_DRV2_EN];
      full_ask_force        <= auto_ctrl[adc_pkg::AC_FORCE_ASK];
      collision_avoid_on    <= auto_ctrl[adc_pkg::AC_COLL_AVOID];
      collision_slot_n      <= auto_ctrl[adc_pkg::AC_COLL_AVOID] ? 4'(SLOT_N) : 4'h0;
      wake_request          <= auto_ctrl[adc_pkg::AC_FIELD_WAKE] && soft_power_down && ext_field;
    end
  end

endmodule

/* File: logic/adc_pkg.sv */
// Package: register map, field positions, reset values and timing for the antenna driver control
package adc_pkg;

  // Register offsets (printed offsets are not all multiples of four: index, byte address = 4 * index)
  localparam logic [7:0]  REG_DRV_CTRL_IDX = 8'h14;
  localparam logic [7:0]  REG_AUTO_CTRL_IDX = 8'h15;
  localparam logic [7:0]  REG_STATUS_IDX = 8'h17;
  localparam logic [11:0] ADDR_DRV_CTRL = {2'h0, REG_DRV_CTRL_IDX, 2'h0};
  localparam logic [11:0] ADDR_AUTO_CTRL = {2'h0, REG_AUTO_CTRL_IDX, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, REG_STATUS_IDX, 2'h0};

  // Driver control fields
  localparam int DC_DRV2_INV_ON = 7;
  localparam int DC_DRV1_INV_ON = 6;
  localparam int DC_DRV2_INV_OFF = 5;
  localparam int DC_DRV1_INV_OFF = 4;
  localparam int DC_DRV2_CW = 3;
  localparam int DC_FIELD_CHECK = 2;
  localparam int DC_DRV2_EN = 1;
  localparam int DC_DRV1_EN = 0;

  // Automatic control fields
  localparam int AC_AUTO_OFF = 7;
  localparam int AC_FORCE_ASK = 6;
  localparam int AC_FIELD_WAKE = 5;
  localparam int AC_RESERVED = 4;
  localparam int AC_COLL_AVOID = 3;
  localparam int AC_INIT_AVOID = 2;
  localparam int AC_DRV2_AUTO = 1;
  localparam int AC_DRV1_AUTO = 0;

  // Reset values and access masks
  localparam logic [7:0] DRV_CTRL_RESET = 8'h80;
  localparam logic [7:0] AUTO_CTRL_RESET = 8'h00;
  localparam logic [7:0] AUTO_CTRL_WMASK = 8'hef;
  localparam logic [7:0] DRV_CTRL_RMASK = 8'hfb;

  // Delay times in carrier-derived clock cycles, and the collision slot count
  localparam int ACTIVE_DELAY_CYCLES = 1024;
  localparam int INITIAL_DELAY_CYCLES = 2048;
  localparam int COLL_SLOT_N = 3;

  // Source select for the drivers
  typedef enum logic [1:0] {
    ADC_SRC_OFF,
    ADC_SRC_CODER,
    ADC_SRC_EXT,
    ADC_SRC_HIGH
  } adc_src_e;

  // Driver pin pair and analog hints
  typedef struct packed {
    logic drv1;
    logic drv2;
    logic drv1_on;
    logic drv2_on;
  } adc_drive_s;

  // Automatic sequencer states
  typedef enum logic [1:0] {
    ADC_IDLE,
    ADC_WAIT_FIELD_OFF,
    ADC_DELAY,
    ADC_DONE
  } adc_auto_e;

endpackage

/* File: logic/adc_delay_timer.sv */
// Delay counter that runs while a condition holds and pulses when the count is reached
module adc_delay_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit,
  // Result
  output logic                  expired
);

  logic [CNT_W-1:0] count;
  wire              at_limit = (count >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= '0;
      expired <= 1'b0;
    end else if (!run) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      expired <= at_limit && !expired;
      if (!at_limit) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

/* File: tb/adc_checker.sv */
// Checker: port-level properties of the antenna driver control
module adc_checker #(
  parameter int SLOT_N = 3
) (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  // Transmit, field and power
  input wire logic                tx_last_bit_done,
  input wire logic                ext_field,
  input wire logic                soft_power_down,
  // Outputs watched
  input wire adc_pkg::adc_drive_s antenna_drive,
  input wire logic                full_ask_force,
  input wire logic                collision_avoid_on,
  input wire logic [3:0]          collision_slot_n,
  input wire logic                wake_request
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Decodes and properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel && penable && pwrite && pstrb[0];
  wire wr_a   = acc && paddr == adc_pkg::ADDR_AUTO_CTRL;
  wire wr_d   = acc && paddr == adc_pkg::ADDR_DRV_CTRL;
  wire rd_a   = psel && !penable && !pwrite && paddr == adc_pkg::ADDR_AUTO_CTRL;
  wire rd_d   = psel && !penable && !pwrite && paddr == adc_pkg::ADDR_DRV_CTRL;
  wire on_any = antenna_drive.drv1_on || antenna_drive.drv2_on;
  // Shadow of the auto-off and automatic enable bits as last written
  logic [2:0] auto_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_q <= 3'h0;
    end else if (wr_a) begin
      auto_q <= {pwdata[7], pwdata[1:0]};
    end
  end
  a_ask_copy: assert property (wr_a |-> ##2 full_ask_force == $past(pwdata[6], 2))
    else $error("force ask output wrong");
  a_avoid_copy: assert property (wr_a |-> ##2 collision_avoid_on == $past(pwdata[3], 2))
    else $error("collision avoid output wrong");
  a_slot_count: assert property (wr_a |-> ##2 collision_slot_n == ($past(pwdata[3], 2) ? 4'(SLOT_N) : 4'h0))
    else $error("slot count wrong");
  a_wake_field: assert property (!ext_field |=> !wake_request)
    else $error("wake without field");
  a_wake_power: assert property (!soft_power_down |=> !wake_request)
    else $error("wake while powered");
  a_auto_off: assert property (tx_last_bit_done && auto_q[2] && auto_q[1:0] == 2'h0 |-> ##2 !on_any)
    else $error("driver still on after last bit");
  a_check_block: assert property (wr_d && pwdata[2] && pwdata[0] && ext_field && !antenna_drive.drv1_on
    |-> ##2 !antenna_drive.drv1_on)
    else $error("enable set despite field");
  a_resv_zero: assert property (rd_a |=> prdata[4] == 1'h0 && prdata[31:8] == 24'h0)
    else $error("reserved bit not zero");
  a_check_zero: assert property (rd_d |=> prdata[2] == 1'h0)
    else $error("write-only bit read back");
endmodule

/* File: tb/adc_field_model.sv */
// Far side: carrier source and external field detector
module adc_field_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench command
  input  wire logic field_cmd,
  // Carrier and detector
  output logic      carrier,
  output logic      ext_field
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier <= 1'h0;
      ext_field <= 1'h0;
    end else begin
      carrier <= ~carrier;
      ext_field <= field_cmd;
    end
  end
endmodule

/* File: tb/test_antenna_driver_control.sv */
// Testbench: registers, driver levels, field check, automatic switching
module test_antenna_driver_control;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int          ACT = 8;
  localparam int          INI = 16;
  localparam logic [11:0] DRV = adc_pkg::ADDR_DRV_CTRL;
  localparam logic [11:0] AUT = adc_pkg::ADDR_AUTO_CTRL;
  logic                   pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic                   tx_envelope = 1'h0, tx_last_bit_done = 1'h0, soft_power_down = 1'h0, field_cmd = 1'h1;
  logic [11:0]            paddr = 12'h0;
  logic [31:0]            pwdata = 32'h0, prdata, rd;
  logic [3:0]             pstrb = 4'h1, collision_slot_n;
  logic [1:0]             driver_source_select = 2'h0;
  logic                   pready, pslverr, err, carrier, ext_field, full_ask_force, collision_avoid_on, wake_request;
  adc_pkg::adc_drive_s    antenna_drive;
  logic [7:0]             md = 8'h80, ma = 8'h00;
  int                     failures = 0, n_checks = 0, n;
  always #2 pclk = ~pclk;
  adc_antenna_ctrl #(.ACTIVE_DELAY(ACT), .INITIAL_DELAY(INI)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .carrier(carrier), .tx_envelope(tx_envelope),
    .tx_last_bit_done(tx_last_bit_done), .driver_source_select(driver_source_select), .ext_field(ext_field),
    .soft_power_down(soft_power_down), .antenna_drive(antenna_drive), .full_ask_force(full_ask_force),
    .collision_avoid_on(collision_avoid_on), .collision_slot_n(collision_slot_n), .wake_request(wake_request));
  adc_field_model far (.pclk(pclk), .presetn(presetn), .field_cmd(field_cmd), .carrier(carrier),
    .ext_field(ext_field));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
    if (a == AUT) ma = d & 8'hef;
    if (a == DRV) md = {d[7:3], 1'h0, d[1:0] & ((d[2] && ext_field) ? md[1:0] : 2'h3)};
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    cmp(nm, {24'h0, e}, rd);
  endtask
  task automatic cd();
    logic s1, s2, h;
    @(posedge pclk);
    h = driver_source_select == 2'h3;
    s1 = h | (carrier & ~tx_envelope);
    s2 = h | (carrier & (~tx_envelope | md[3]));
    #1;
    cmp("drive", {28'h0, md[0] ? s1 ^ md[6] : md[4], md[1] ? s2 ^ md[7] : md[5], md[0], md[1]}, {28'h0, antenna_drive});
  endtask
  task automatic won(input int d);
    field_cmd <= 1'h0;
    repeat (d / 2) @(posedge pclk);
    field_cmd <= 1'h1;
    repeat (2) @(posedge pclk);
    field_cmd <= 1'h0;
    n = 0;
    while (!(antenna_drive.drv1_on === 1'h1 && antenna_drive.drv2_on === 1'h1) && n < 4 * d) begin
      @(posedge pclk);
      n++;
    end
    cmp("on_delay", 32'h1, {31'h0, n >= d && n <= d + 8});
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(32'h5ecb595a));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rc("drv_reset", DRV, md);
    rc("auto_reset", AUT, ma);
    cd();
    apb(1'h0, 12'h0f0, 8'h00);
    cmp("slverr", 32'h1, {31'h0, err});
    wr(AUT, 8'hff);
    rc("auto_bits", AUT, ma);
    cmp("ask", 32'h1, {31'h0, full_ask_force});
    cmp("avoid", {31'h0, ma[3]}, {31'h0, collision_avoid_on});
    cmp("slot_n", 32'h3, {28'h0, collision_slot_n});
    wr(AUT, 8'h00);
    pstrb <= 4'h0;
    apb(1'h1, AUT, 8'hff);
    pstrb <= 4'h1;
    rc("auto_strobe", AUT, ma);
    for (int i = 0; i < 16; i++) begin
      wr(DRV, 8'($urandom) & 8'hfb);
      tx_envelope <= 1'($urandom);
      driver_source_select <= 2'($urandom);
      cd();
      cd();
    end
    wr(DRV, 8'h00);
    for (int k = 0; k < 3; k++) begin
      field_cmd <= (k != 1);
      repeat (3) @(posedge pclk);
      wr(DRV, 8'h07);
      rc("drv_check", DRV, md);
    end
    wr(AUT, 8'h80);
    tx_last_bit_done <= 1'h1;
    @(posedge pclk);
    tx_last_bit_done <= 1'h0;
    md[1:0] = 2'h0;
    rc("drv_auto_off", DRV, md);
    wr(AUT, 8'h20);
    for (int j = 0; j < 2; j++) begin
      soft_power_down <= (j == 0);
      repeat (3) @(posedge pclk);
      cmp("wake", {31'h0, ma[5] & soft_power_down & ext_field}, {31'h0, wake_request});
    end
    for (int m = 0; m < 2; m++) begin
      wr(DRV, 8'h00);
      wr(AUT, m ? 8'h07 : 8'h03);
      won(m ? INI : ACT);
      md[1:0] = 2'h3;
      ma[2] = 1'h0;
      rc("auto_initial", AUT, ma);
      rc("drv_auto_on", DRV, md);
      wr(AUT, 8'h00);
      field_cmd <= 1'h1;
    end
    close_out();
  end
endmodule
bind adc_antenna_ctrl adc_checker #(.SLOT_N(SLOT_N)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .tx_last_bit_done(tx_last_bit_done), .ext_field(ext_field), .soft_power_down(soft_power_down),
  .antenna_drive(antenna_drive), .full_ask_force(full_ask_force), .collision_avoid_on(collision_avoid_on),
  .collision_slot_n(collision_slot_n), .wake_request(wake_request));
